// [ecs_pkg.sv]
// shared constants and types for the nvm command and status controller
package ecs_pkg;

  // register byte offsets on the AHB-Lite bus, one aligned word each
  localparam logic [7:0] ADDR_CONFIG     = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_COMMAND    = 8'h08;
  localparam logic [7:0] ADDR_FACTORY    = 8'h0C;
  localparam logic [7:0] ADDR_DIVIDER    = 8'h10;
  localparam logic [7:0] ADDR_ARRAY_WORD = 8'h14;

  // status register bit positions
  localparam int ST_BUF_EMPTY = 7;
  localparam int ST_COMPLETE  = 6;
  localparam int ST_PROTECTION_VIOLATION_FLAG     = 5;
  localparam int ST_ACCESS_ERROR_FLAG    = 4;
  localparam int ST_BLANK     = 2;
  localparam int ST_FAIL      = 1;
  localparam int ST_DONE      = 0;

  // config register bit positions
  localparam int CFG_BUF_EMPTY_IE = 7;
  localparam int CFG_COMPLETE_IE  = 6;

  // divider register layout
  localparam int DIV_LOADED = 7;
  localparam int DIV_WIDTH  = 7;

  // array word register layout: data in the low half, byte address above
  localparam int ARR_DATA_LSB  = 0;
  localparam int ARR_DATA_W    = 16;
  localparam int ARR_ADDR_LSB  = 16;
  localparam int ARR_ADDR_W    = 11;

  // command register: only these bits are implemented
  localparam logic [7:0] CMD_BITS_MASK = 8'h65;

  // operation codes
  localparam logic [7:0] OP_ERASE_VERIFY  = 8'h05;
  localparam logic [7:0] OP_WORD_PROGRAM  = 8'h20;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h40;
  localparam logic [7:0] OP_MASS_ERASE    = 8'h41;
  localparam logic [7:0] OP_SECTOR_MODIFY = 8'h60;

  // reset values
  localparam logic [7:0]             CONFIG_RST   = 8'h00;
  localparam logic [7:0]             COMMAND_RST  = 8'h00;
  localparam logic [DIV_WIDTH-1:0]   DIVIDER_RST  = 7'h00;
  localparam logic                   BUF_EMPTY_RST = 1'b1;
  localparam logic                   COMPLETE_RST  = 1'b1;

  // command write sequence progress
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WORD,
    SEQ_CMD
  } ecs_seq_e;

endpackage

// [ecs_ctrl.sv]
// command register, status flags and command buffer of the nvm controller
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/100ps

module ecs_ctrl (
  input  wire logic                            clk,
  input  wire logic                            reset_n,
  // AHB-Lite slave
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output logic      [31:0]                     hrdata,
  output logic                                 hreadyout,
  output logic                                 hresp,
  // mode and cpu
  input  wire logic                            special_mode,
  input  wire logic                            cpu_stop,
  // protection logic judges the buffered address
  input  wire logic                            area_protected,
  input  wire logic                            protection_open,
  output logic      [ecs_pkg::ARR_ADDR_W-1:0]  seq_addr,
  // array engine
  output logic                                 op_start,
  output logic      [7:0]                      op_code,
  output logic      [ecs_pkg::ARR_ADDR_W-1:0]  op_addr,
  output logic      [ecs_pkg::ARR_DATA_W-1:0]  op_data,
  input  wire logic                            op_finish,
  input  wire logic                            op_blank,
  output logic      [ecs_pkg::DIV_WIDTH-1:0]   timebase_divider,
  // interrupt requests
  output logic                                 buffer_empty_irq,
  output logic                                 complete_irq
);

  // legal operation code check, used by command write decode
  function automatic logic ecs_code_legal(input logic [7:0] code);
    ecs_code_legal = (code == ecs_pkg::OP_ERASE_VERIFY) ||
                     (code == ecs_pkg::OP_WORD_PROGRAM) ||
                     (code == ecs_pkg::OP_SECTOR_ERASE) ||
                     (code == ecs_pkg::OP_MASS_ERASE) ||
                     (code == ecs_pkg::OP_SECTOR_MODIFY);
  endfunction

  logic                              a_valid, wr_pend_reg, rd_wait_reg;
  logic [7:0]                        a_addr_reg, wd, cmd_reg, act_code_reg, status_rd, rd_byte;
  logic [31:0]                       hrdata_reg;
  logic                              wr_cfg, wr_stat, wr_cmd, wr_div, wr_arr;
  logic                              cfg_beie_reg, cfg_complete_irq_enable_reg, div_loaded_reg;
  logic [ecs_pkg::DIV_WIDTH-1:0]     div_reg;
  logic                              buf_empty_reg, complete_reg, protection_violation_flag_reg, access_error_flag_reg, blank_reg, fail_reg;
  ecs_pkg::ecs_seq_e                 seq_reg, seq_next;
  logic [ecs_pkg::ARR_ADDR_W-1:0]    seq_addr_reg, act_addr_reg, arr_addr_in;
  logic [ecs_pkg::ARR_DATA_W-1:0]    seq_data_reg, act_data_reg;
  logic                              act_valid_reg, op_start_reg;
  logic                              seq_fault, prot_fault, launch_ok, word_take, cmd_take;
  logic                              transfer, act_done, verify_done, stop_fault;

  // address phase acceptance
  assign a_valid = hsel && hready && htrans[1];

  // reads take one wait state so hrdata comes from a flop and sees prior writes
  assign hreadyout = !rd_wait_reg;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // address phase capture
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      a_addr_reg  <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= a_valid && hwrite;
      rd_wait_reg <= a_valid && !hwrite;
      if (a_valid)
        a_addr_reg <= {haddr[7:2], 2'b00};
    end
  end

  // write strobes in the data phase; the low byte carries register data, except the array word, which takes hwdata bits 26:0
  assign wd      = hwdata[7:0];
  assign wr_cfg  = wr_pend_reg && (a_addr_reg == ecs_pkg::ADDR_CONFIG);
  assign wr_stat = wr_pend_reg && (a_addr_reg == ecs_pkg::ADDR_STATUS);
  assign wr_cmd  = wr_pend_reg && (a_addr_reg == ecs_pkg::ADDR_COMMAND);
  assign wr_div  = wr_pend_reg && (a_addr_reg == ecs_pkg::ADDR_DIVIDER);
  assign wr_arr  = wr_pend_reg && (a_addr_reg == ecs_pkg::ADDR_ARRAY_WORD);
  assign arr_addr_in = hwdata[ecs_pkg::ARR_ADDR_LSB +: ecs_pkg::ARR_ADDR_W];

  // status read view; special-mode bits hidden in normal mode
  always_comb
  begin
    status_rd = 8'h00;
    status_rd[ecs_pkg::ST_BUF_EMPTY] = buf_empty_reg;
    status_rd[ecs_pkg::ST_COMPLETE]  = complete_reg;
    status_rd[ecs_pkg::ST_PROTECTION_VIOLATION_FLAG]     = protection_violation_flag_reg;
    status_rd[ecs_pkg::ST_ACCESS_ERROR_FLAG]    = access_error_flag_reg;
    status_rd[ecs_pkg::ST_BLANK]     = blank_reg;
    status_rd[ecs_pkg::ST_FAIL]      = special_mode && fail_reg;
    status_rd[ecs_pkg::ST_DONE]      = special_mode && !act_valid_reg;
  end

  // read mux; factory test and unmapped words read zero
  always_comb
  begin
    rd_byte = 8'h00;
    case (a_addr_reg)
      ecs_pkg::ADDR_CONFIG:  rd_byte = {cfg_beie_reg, cfg_complete_irq_enable_reg, 6'h00};
      ecs_pkg::ADDR_STATUS:  rd_byte = status_rd;
      ecs_pkg::ADDR_COMMAND: rd_byte = cmd_reg & ecs_pkg::CMD_BITS_MASK;
      ecs_pkg::ADDR_DIVIDER: rd_byte = {div_loaded_reg, div_reg};
      ecs_pkg::ADDR_FACTORY: rd_byte = 8'h00;
      default:               rd_byte = 8'h00;
    endcase
  end

  // read data register loaded during the wait state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hrdata_reg <= 32'h0000_0000;
    else if (rd_wait_reg)
      hrdata_reg <= {24'h00_0000, rd_byte};
  end

  // interrupt enables
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_beie_reg <= ecs_pkg::CONFIG_RST[ecs_pkg::CFG_BUF_EMPTY_IE];
      cfg_complete_irq_enable_reg <= ecs_pkg::CONFIG_RST[ecs_pkg::CFG_COMPLETE_IE];
    end
    else if (wr_cfg)
    begin
      cfg_beie_reg <= wd[ecs_pkg::CFG_BUF_EMPTY_IE];
      cfg_complete_irq_enable_reg <= wd[ecs_pkg::CFG_COMPLETE_IE];
    end
  end

  // divider is write once; the loaded bit gates every launch
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_reg        <= ecs_pkg::DIVIDER_RST;
      div_loaded_reg <= 1'b0;
    end
    else if (wr_div && !div_loaded_reg)
    begin
      div_reg        <= wd[ecs_pkg::DIV_WIDTH-1:0];
      div_loaded_reg <= 1'b1;
    end
  end
  assign timebase_divider = div_reg;

  // sequence decode: word write, command write, launch or abort
  always_comb
  begin
    seq_next   = seq_reg;
    seq_fault  = 1'b0;
    prot_fault = 1'b0;
    launch_ok  = 1'b0;
    word_take  = 1'b0;
    cmd_take   = 1'b0;
    if (wr_arr)
    begin
      // new word while errors stand is ignored; misaligned or busy is a fault
      if (!(access_error_flag_reg || protection_violation_flag_reg))
      begin
        if ((seq_reg != ecs_pkg::SEQ_IDLE) || !buf_empty_reg || arr_addr_in[0])
        begin
          seq_fault = 1'b1;
          seq_next  = ecs_pkg::SEQ_IDLE;
        end
        else
        begin
          word_take = 1'b1;
          seq_next  = ecs_pkg::SEQ_WORD;
        end
      end
    end
    else if (wr_cmd)
    begin
      if ((seq_reg != ecs_pkg::SEQ_WORD) || !ecs_code_legal(wd))
      begin
        seq_fault = (seq_reg != ecs_pkg::SEQ_IDLE) || !ecs_code_legal(wd);
        seq_next  = ecs_pkg::SEQ_IDLE;
      end
      else
      begin
        cmd_take = 1'b1;
        seq_next = ecs_pkg::SEQ_CMD;
      end
    end
    else if (wr_stat && !wd[ecs_pkg::ST_BUF_EMPTY])
    begin
      // zero to buffer-empty aborts a started sequence, harmless when idle
      if (seq_reg != ecs_pkg::SEQ_IDLE)
      begin
        seq_fault = 1'b1;
        seq_next  = ecs_pkg::SEQ_IDLE;
      end
    end
    else if (wr_stat && buf_empty_reg)
    begin
      if (seq_reg == ecs_pkg::SEQ_WORD)
      begin
        seq_fault = 1'b1;
        seq_next  = ecs_pkg::SEQ_IDLE;
      end
      else if (seq_reg == ecs_pkg::SEQ_CMD)
      begin
        seq_next = ecs_pkg::SEQ_IDLE;
        if (access_error_flag_reg || !div_loaded_reg)
          seq_fault = 1'b1;
        else if (((cmd_reg == ecs_pkg::OP_MASS_ERASE) && !protection_open) ||
                 ((cmd_reg != ecs_pkg::OP_ERASE_VERIFY) &&
                  (cmd_reg != ecs_pkg::OP_MASS_ERASE) && area_protected))
          prot_fault = 1'b1;
        else if (!protection_violation_flag_reg)
          launch_ok = 1'b1;
        else
          seq_fault = 1'b1;
      end
    end
  end

  // sequence state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      seq_reg <= ecs_pkg::SEQ_IDLE;
    else
      seq_reg <= seq_next;
  end

  // sequence buffers double as the pending stage of the two-stage queue
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seq_addr_reg <= '0;
      seq_data_reg <= '0;
      cmd_reg      <= ecs_pkg::COMMAND_RST;
    end
    else
    begin
      if (word_take)
      begin
        seq_addr_reg <= arr_addr_in;
        seq_data_reg <= hwdata[ecs_pkg::ARR_DATA_LSB +: ecs_pkg::ARR_DATA_W];
      end
      if (cmd_take)
        cmd_reg <= wd & ecs_pkg::CMD_BITS_MASK;
    end
  end
  assign seq_addr = seq_addr_reg;

  // pending moves to active when the engine is free or just finishing
  assign act_done    = act_valid_reg && op_finish;
  assign transfer    = !buf_empty_reg && (!act_valid_reg || op_finish);
  assign verify_done = act_done && (act_code_reg == ecs_pkg::OP_ERASE_VERIFY);
  assign stop_fault  = cpu_stop && !complete_reg;

  // active stage and start pulse to the array engine
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      act_valid_reg <= 1'b0;
      act_code_reg  <= 8'h00;
      act_addr_reg  <= '0;
      act_data_reg  <= '0;
      op_start_reg  <= 1'b0;
    end
    else
    begin
      op_start_reg <= transfer;
      if (transfer)
      begin
        act_valid_reg <= 1'b1;
        act_code_reg  <= cmd_reg;
        act_addr_reg  <= seq_addr_reg;
        act_data_reg  <= seq_data_reg;
      end
      else if (act_done)
        act_valid_reg <= 1'b0;
    end
  end
  assign op_start = op_start_reg;
  assign op_code  = act_code_reg;
  assign op_addr  = act_addr_reg;
  assign op_data  = act_data_reg;

  // buffer empty: cleared by launch, set when the pending stage drains
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      buf_empty_reg <= ecs_pkg::BUF_EMPTY_RST;
    else if (launch_ok)
      buf_empty_reg <= 1'b0;
    else if (transfer)
      buf_empty_reg <= 1'b1;
  end

  // complete: software writes have no path here
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      complete_reg <= ecs_pkg::COMPLETE_RST;
    else if (launch_ok)
      complete_reg <= 1'b0;
    else if (act_done && buf_empty_reg)
      complete_reg <= 1'b1;
  end

  // access error: any set source beats a same-cycle clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      access_error_flag_reg <= 1'b0;
    else if (seq_fault || stop_fault)
      access_error_flag_reg <= 1'b1;
    else if (wr_stat && wd[ecs_pkg::ST_ACCESS_ERROR_FLAG])
      access_error_flag_reg <= 1'b0;
  end

  // protection violation, cleared only by its own bit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      protection_violation_flag_reg <= 1'b0;
    else if (prot_fault)
      protection_violation_flag_reg <= 1'b1;
    else if (wr_stat && wd[ecs_pkg::ST_PROTECTION_VIOLATION_FLAG])
      protection_violation_flag_reg <= 1'b0;
  end

  // blank: hardware only, no write path
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      blank_reg <= 1'b0;
    else if (verify_done && op_blank)
      blank_reg <= 1'b1;
    else if (launch_ok)
      blank_reg <= 1'b0;
  end

  // fail: clearable only in special mode; relies on software clearing it first
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fail_reg <= 1'b0;
    else if (verify_done && !op_blank)
      fail_reg <= 1'b1;
    else if (special_mode && wr_stat && wd[ecs_pkg::ST_FAIL])
      fail_reg <= 1'b0;
  end

  // interrupt requests are plain level gates of flag and enable
  assign buffer_empty_irq = buf_empty_reg && cfg_beie_reg;
  assign complete_irq     = complete_reg && cfg_complete_irq_enable_reg;

endmodule

// [ecs_ctrl_chk.sv]
// assertion checker for the nvm command and status controller
`timescale 1ns/100ps
module ecs_chk (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        special_mode,
  input wire logic        op_start,
  input wire logic [7:0]  op_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic rd_go;
  logic wr_go;
  // transfers accepted on the bus
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign wr_go = hsel && hready && htrans[1] && hwrite;

  resp_okay_a: assert property (hresp == 1'b0) else $error("bus response not okay");
  read_wait_a: assert property (rd_go |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  write_nowait_a: assert property (wr_go |=> hreadyout) else $error("write stalled");
  factory_zero_a: assert property (rd_go && haddr[7:0] == ecs_pkg::ADDR_FACTORY |-> ##2 hrdata == 32'h0)
    else $error("factory register not zero");
  upper_zero_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0) else $error("upper read bits set");
  cmd_mask_a: assert property (rd_go && haddr[7:0] == ecs_pkg::ADDR_COMMAND |-> ##2
    (hrdata[7:0] & ~ecs_pkg::CMD_BITS_MASK) == 8'h00) else $error("unused command bits set");
  status_norm_a: assert property (rd_go && haddr[7:0] == ecs_pkg::ADDR_STATUS && !special_mode |-> ##2
    {hrdata[3], hrdata[1:0]} == 3'b000) else $error("hidden status bits set");
  op_legal_a: assert property (op_start |-> op_code inside {8'h05, 8'h20, 8'h40, 8'h41, 8'h60})
    else $error("illegal code started");
  op_hold_a: assert property ($changed(op_code) |-> op_start) else $error("active code changed");
  start_once_a: assert property (op_start |=> !op_start) else $error("start pulse too long");
  cover property (op_start ##[1:100] op_start);
  cover property (rd_go && haddr[7:0] == ecs_pkg::ADDR_STATUS);
  cover property (wr_go && haddr[7:0] == ecs_pkg::ADDR_COMMAND);
endmodule

bind ecs_ctrl ecs_chk u_ecs_chk (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .special_mode, .op_start, .op_code);

// [ecs_engine_model.sv]
// behavioural array engine: finishes each started operation after a set delay
`timescale 1ns/100ps
module ecs_engine_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       op_start,
  input  wire logic [7:0] lat,
  input  wire logic       blank,
  output logic            op_finish,
  output logic            op_blank
);
  logic [7:0] cnt_reg;
  // countdown per operation; a lat of 0 never raises finish
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_reg   <= 8'h00;
      op_finish <= 1'b0;
    end
    else
    begin
      op_finish <= (cnt_reg == 8'h01);
      if (op_start)
        cnt_reg <= lat;
      else if (cnt_reg != 8'h00)
        cnt_reg <= cnt_reg - 8'h01;
    end
  end
  // result line only valid with finish, inverted otherwise
  assign op_blank = op_finish ? blank : ~blank;
endmodule

// [ecs_ctrl_bench.sv]
// self-checking bench for the nvm command and status controller
`timescale 1ns/100ps
module ecs_ctrl_bench;
  localparam logic [7:0] CF = ecs_pkg::ADDR_CONFIG;
  localparam logic [7:0] ST = ecs_pkg::ADDR_STATUS;
  localparam logic [7:0] CM = ecs_pkg::ADDR_COMMAND;
  localparam logic [7:0] FT = ecs_pkg::ADDR_FACTORY;
  logic        clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, special_mode, cpu_stop;
  logic        area_protected, protection_open, op_start, op_finish, op_blank, blank;
  logic        buffer_empty_irq, complete_irq;
  logic        rd_ph = 1'b0;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [10:0] seq_addr, op_addr, sa;
  logic [15:0] op_data, sd;
  logic [7:0]  op_code, lat;
  logic [6:0]  timebase_divider;
  logic [15:0] expq[$];
  logic [7:0]  codes[5] = '{8'h05, 8'h20, 8'h40, 8'h41, 8'h60};
  int          num_errors, compares, fins;

  assign hready = hreadyout;
  ecs_ctrl u_ecs_ctrl (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .special_mode, .cpu_stop, .area_protected, .protection_open, .seq_addr, .op_start,
    .op_code, .op_addr, .op_data, .op_finish, .op_blank, .timebase_divider, .buffer_empty_irq, .complete_irq);
  ecs_engine_model u_ecs_engine_model (.clk, .reset_n, .op_start, .lat, .blank, .op_finish, .op_blank);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task end_sim;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // hready looked at mid-cycle so the edge after it is the sampling edge
  task waitrdy;
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1)
    begin
      num_errors++;
      end_sim;
    end
    @(posedge clk);
  endtask

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsel   <= 1'b1;
    waitrdy;
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    waitrdy;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  // expected value noted before the read, checked by the monitor
  task rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({a, e});
    xfer(a, 1'b0, 32'h0);
  endtask

  // word then command: the first two steps of a sequence
  task seq(input logic [7:0] code);
    sa = 11'($urandom) & 11'h7FE;
    sd = 16'($urandom);
    wr(ecs_pkg::ADDR_ARRAY_WORD, {5'h0, sa, sd});
    wr(CM, {24'h0, code});
  endtask

  task waitfin(input int k);
    int n;
    n = 0;
    while (fins < k && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (fins < k)
    begin
      num_errors++;
      end_sim;
    end
  endtask

  // monitor: read data taken where the data phase completes
  always @(posedge clk)
  begin
    if (op_finish === 1'b1)
      fins++;
    if (rd_ph && hreadyout === 1'b1)
    begin
      chk($sformatf("reg %h", expq[0][15:8]), {24'h0, expq[0][7:0]}, hrdata);
      void'(expq.pop_front());
      rd_ph <= 1'b0;
    end
    if (hsel && hready && htrans[1] && !hwrite)
      rd_ph <= 1'b1;
  end

  initial
  begin
    {hsel, hwrite, special_mode, cpu_stop, area_protected} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'b010;
    protection_open = 1'b1;
    blank = 1'b1;
    lat = 8'd20;
    reset_n = 1'b0;
    void'($urandom(32'h2bef));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd(ST, 8'hC0);
    rd(CF, 8'h00);
    wr(FT, 32'hFF);
    rd(FT, 8'h00);
    seq(8'h20);
    wr(ST, 32'h80);
    rd(ST, 8'hD0);
    wr(ST, 32'h10);
    rd(ST, 8'hC0);
    wr(ecs_pkg::ADDR_DIVIDER, 32'h04);
    // second write must not take: the divider is write once
    wr(ecs_pkg::ADDR_DIVIDER, 32'h7F);
    rd(ecs_pkg::ADDR_DIVIDER, 8'h84);
    chk("divider", 32'h04, {25'h0, timebase_divider});
    wr(CF, 32'hC0);
    foreach (codes[i])
    begin
      lat <= 8'(10 + $urandom % 20);
      seq(codes[i]);
      rd(CM, codes[i]);
      chk("seq addr", {21'h0, sa}, {21'h0, seq_addr});
      wr(ST, 32'h80);
      rd(ST, 8'h80);
      chk("irq busy", 2'b10, {buffer_empty_irq, complete_irq});
      waitfin(fins + 1);
      chk("op word", {5'h0, sa, sd}, {5'h0, op_addr, op_data});
      rd(ST, codes[i] == 8'h05 ? 8'hC4 : 8'hC0);
      chk("irq idle", 2'b11, {buffer_empty_irq, complete_irq});
    end
    foreach (codes[i])
    begin
      seq(codes[i] ^ 8'h01);
      rd(ST, (codes[i] ^ 8'h01) inside {8'h40, 8'h41} ? 8'hC0 : 8'hD0);
      // a legal code leaves the sequence open: first write aborts it, second clears the error
      wr(ST, 32'h10);
      wr(ST, 32'h10);
    end
    wr(ecs_pkg::ADDR_ARRAY_WORD, 32'h0);
    wr(ST, 32'h00);
    rd(ST, 8'hD0);
    wr(ST, 32'h50);
    wr(ST, 32'h00);
    rd(ST, 8'hC0);
    lat <= 8'd40;
    seq(8'h20);
    wr(ST, 32'h80);
    seq(8'h40);
    wr(ST, 32'h80);
    rd(ST, 8'h00);
    waitfin(fins + 1);
    rd(ST, 8'h80);
    waitfin(fins + 1);
    rd(ST, 8'hC0);
    seq(8'h60);
    wr(ST, 32'h80);
    cpu_stop <= 1'b1;
    @(posedge clk);
    cpu_stop <= 1'b0;
    waitfin(fins + 1);
    rd(ST, 8'hD0);
    wr(ST, 32'h10);
    area_protected <= 1'b1;
    seq(8'h20);
    wr(ST, 32'h80);
    rd(ST, 8'hE0);
    wr(CM, 32'h21);
    rd(ST, 8'hF0);
    wr(ST, 32'h20);
    rd(ST, 8'hD0);
    wr(ST, 32'h10);
    protection_open <= 1'b0;
    seq(8'h41);
    wr(ST, 32'h80);
    rd(ST, 8'hE0);
    wr(ST, 32'h20);
    {area_protected, protection_open, special_mode, blank} <= 4'b0110;
    rd(ST, 8'hC1);
    seq(8'h05);
    wr(ST, 32'h80);
    repeat (3) @(posedge clk);
    rd(ST, 8'h80);
    waitfin(fins + 1);
    rd(ST, 8'hC3);
    wr(ST, 32'h02);
    rd(ST, 8'hC1);
    end_sim;
  end
endmodule
